// ### tag_pkg.sv
package tag_pkg;

   // ======================================================
   // memory organisation
   localparam int BLOCKS = 10;
   localparam int BLOCK_W = 33;
   localparam int ADDR_W = 4;
   localparam logic [3:0] CFG_BLOCK = 4'h0;
   localparam logic [3:0] PWD_BLOCK = 4'h7;
   localparam logic [3:0] PAGE1_BASE = 4'h7;
   localparam int LOCK_BIT = 32;

   // ======================================================
   // configuration word layout, bit 31 is the first bit on air
   localparam logic [31:0] CFG_RESET = 32'h00148000;
   localparam int KEY_LSB = 28;
   localparam int XRATE_LSB = 18;
   localparam int MOD_LSB = 12;
   localparam int LAST_READ_BLOCK_LSB = 5;
   localparam int PWD_BIT = 4;
   localparam int PORDLY_BIT = 0;
   localparam logic [3:0] KEY_NO_TEST = 4'h6;
   localparam logic [3:0] KEY_EXT = 4'h9;
   localparam logic [4:0] MOD_DIRECT = 5'h00;
   localparam logic [4:0] MOD_MANCHESTER = 5'h08;
   localparam logic [4:0] MOD_BIPHASE = 5'h10;

   // ======================================================
   // downlink opcodes and frame lengths after the opcode
   localparam logic [1:0] OP_RESET = 2'h0;
   localparam logic [1:0] OP_TEST = 2'h1;
   localparam logic [1:0] OP_PAGE0 = 2'h2;
   localparam logic [1:0] OP_PAGE1 = 2'h3;
   localparam int BODY_W = 68;
   localparam logic [6:0] LEN_WRITE = 7'h24;
   localparam logic [6:0] LEN_ACCESS = 7'h04;
   localparam logic [6:0] LEN_PWD = 7'h20;

   // ======================================================
   // timing, in field clocks; sys_clk is the recovered carrier
   localparam int CYC_PER_FC = 1;
   localparam int LOAD_FC = 192;
   localparam int POR_DELAY_FC = 8190;
   localparam int ZERO_MIN_FC = 16;
   localparam int ONE_MIN_FC = 40;
   localparam int FRAME_END_FC = 72;
   localparam int LOAD_CYC = LOAD_FC * CYC_PER_FC;
   localparam int POR_DELAY_CYC = POR_DELAY_FC * CYC_PER_FC;
   localparam int ZERO_MIN_CYC = ZERO_MIN_FC * CYC_PER_FC;
   localparam int ONE_MIN_CYC = ONE_MIN_FC * CYC_PER_FC;
   localparam int FRAME_END_CYC = FRAME_END_FC * CYC_PER_FC;

   typedef enum logic [2:0] {
      ST_HOLD = 3'h0,
      ST_LOAD = 3'h1,
      ST_DAMP = 3'h3,
      ST_READ = 3'h2,
      ST_RX = 3'h6,
      ST_CHKPW = 3'h7,
      ST_CHKLOCK = 3'h5,
      ST_WRITE = 3'h4
   } tag_state_t;

   // bit period in field clocks
   function automatic logic [7:0] rate_divisor(input logic ext, input logic [5:0] code);
      logic [7:0] d;
      d = 8'h08;
      if (ext) begin
         d = 8'({code, 1'b0}) + 8'h02;
      end else begin
         unique case (code[2:0])
            3'h0: d = 8'h08;
            3'h1: d = 8'h10;
            3'h2: d = 8'h20;
            3'h3: d = 8'h28;
            3'h4: d = 8'h32;
            3'h5: d = 8'h40;
            3'h6: d = 8'h64;
            3'h7: d = 8'h80;
         endcase
      end
      return d;
   endfunction : rate_divisor

endpackage : tag_pkg

// ### tag_memory.sv
`timescale 1ns/1ns

module tag_memory #(
   parameter int BLOCKS = tag_pkg::BLOCKS,
   parameter int WIDTH = tag_pkg::BLOCK_W
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [tag_pkg::ADDR_W-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data,
   input wire logic wr_en,
   input wire logic [tag_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data
);

   logic [WIDTH-1:0] mem_q [BLOCKS];

   // ======================================================
   // block-wise storage, factory image on reset
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < BLOCKS; i++) begin
            mem_q[i] <= '0;
         end
         mem_q[0] <= {1'b0, tag_pkg::CFG_RESET};
         rd_data <= '0;
      end else begin
         if (wr_en && (int'(wr_addr) < BLOCKS)) begin
            mem_q[wr_addr] <= wr_data;
         end
         rd_data <= (int'(rd_addr) < BLOCKS) ? mem_q[rd_addr] : '0;
      end
   end

endmodule : tag_memory

// ### tag_controller.sv
// What this block does
// - extended setting divides field clock by any even ratio from 2 to 128
// - legacy setting offers only divisors 8,16,32,40,50,64,100,128
// - downlink bits come from gap spacing; malformed streams are rejected
// - uplink drives a damping load across both antenna terminals
// - the recovered field carrier is the only clock
// - logic held idle until power-on detector reports supply good
// - first two downlink bits are the opcode
// - with password mode, 32 bits after opcode compared with block 7
// - configuration loaded from block 0 at power-up and while reading
// - configuration refreshed every block read and after reset command
// - factory configuration: block 0 cyclic, Manchester, divide by 64
// - key value 6 makes test-mode writes ignored
// - key other than 6 or 9 disables extended functions
// - ten blocks of 33 bits, one block per access, block 0 config
// - modulated stream inverted while sensor reports high resistance
// - bit 32 of a block locks it, lock bit included
// - 192 clocks of loading, plus 8190 clocks damping with delay bit
// - a gap during initialisation restarts the whole sequence
// - cyclic read sends block 1 (block 0 when last block is 0) bit 1 to last block bit 32, repeats
`timescale 1ns/1ns

module tag_controller #(
   parameter int POR_DELAY_CYCLES = tag_pkg::POR_DELAY_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic por_ok,
   input wire logic field_gap,
   input wire logic sensor_high_r,
   output logic antenna_damping,
   output logic [31:0] tag_configuration,
   output logic init_done,
   output logic write_done,
   output logic frame_error
);

   typedef struct packed {
      logic por_s1;
      logic por_s2;
      logic gap_s1;
      logic gap_s2;
      logic gap_d;
      logic sens_s1;
      logic sens_s2;
      tag_pkg::tag_state_t st;
      logic [13:0] cnt;
      logic [31:0] cfg;
      logic [1:0] op;
      logic [tag_pkg::BODY_W-1:0] body;
      logic [6:0] nbits;
      logic is_write;
      logic [3:0] tgt;
      logic [3:0] blk;
      logic [1:0] fetch;
      logic [4:0] bitn;
      logic [7:0] rc;
      logic [31:0] word;
      logic bp;
      logic damp;
      logic init_done;
      logic write_done;
      logic frame_error;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic [3:0] mem_rd_addr;
   logic [32:0] mem_rd_data;
   logic mem_wr_en;
   logic [32:0] mem_wr_data;

   logic gap_edge;
   logic ext_mode;
   logic [3:0] key;
   logic [2:0] last_read_block;
   logic [3:0] first_blk;
   logic [7:0] div;
   logic half;
   logic bit_val;
   logic enc;
   logic [6:0] body_len;
   logic [31:0] rx_pw;
   logic len_ok;

   // ======================================================
   // block storage
   tag_memory #(
      .BLOCKS(tag_pkg::BLOCKS),
      .WIDTH(tag_pkg::BLOCK_W)
   ) u_mem (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rd_data),
      .wr_en(mem_wr_en),
      .wr_addr(s_q.tgt),
      .wr_data(mem_wr_data)
   );

   // ======================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.write_done = 1'b0;
      s_d.frame_error = 1'b0;
      s_d.por_s1 = por_ok;
      s_d.por_s2 = s_q.por_s1;
      s_d.gap_s1 = field_gap;
      s_d.gap_s2 = s_q.gap_s1;
      s_d.gap_d = s_q.gap_s2;
      s_d.sens_s1 = sensor_high_r;
      s_d.sens_s2 = s_q.sens_s1;
      mem_rd_addr = tag_pkg::CFG_BLOCK;
      mem_wr_en = 1'b0;
      mem_wr_data = {s_q.body[35], s_q.body[34:3]};
      gap_edge = s_q.gap_s2 & ~s_q.gap_d;
      key = s_q.cfg[tag_pkg::KEY_LSB +: 4];
      ext_mode = (key == tag_pkg::KEY_NO_TEST) || (key == tag_pkg::KEY_EXT);
      last_read_block = s_q.cfg[tag_pkg::LAST_READ_BLOCK_LSB +: 3];
      first_blk = (last_read_block == 3'h0) ? 4'h0 : 4'h1;
      div = tag_pkg::rate_divisor(ext_mode, s_q.cfg[tag_pkg::XRATE_LSB +: 6]);
      half = s_q.rc >= {1'b0, div[7:1]};
      bit_val = s_q.word[5'h1F - s_q.bitn];
      body_len = s_q.nbits - 7'h02;
      rx_pw = (body_len == (tag_pkg::LEN_WRITE + tag_pkg::LEN_PWD)) ?
              s_q.body[67:36] : s_q.body[35:4];
      if (s_q.cfg[tag_pkg::PWD_BIT]) begin
         len_ok = (body_len == tag_pkg::LEN_WRITE + tag_pkg::LEN_PWD) ||
                  (body_len == tag_pkg::LEN_ACCESS + tag_pkg::LEN_PWD);
      end else begin
         len_ok = (body_len == tag_pkg::LEN_WRITE) || (body_len == tag_pkg::LEN_ACCESS);
      end
      unique case (s_q.cfg[tag_pkg::MOD_LSB +: 5])
         tag_pkg::MOD_MANCHESTER: enc = half ? bit_val : ~bit_val;
         tag_pkg::MOD_BIPHASE: enc = s_q.bp ^ (half & bit_val);
         default: enc = bit_val;
      endcase

      unique case (s_q.st)
         tag_pkg::ST_HOLD: begin
            s_d.damp = 1'b0;
            s_d.cnt = '0;
            s_d.st = tag_pkg::ST_LOAD;
         end
         tag_pkg::ST_LOAD: begin
            s_d.damp = 1'b0;
            s_d.cnt = s_q.cnt + 14'h0001;
            if (gap_edge) begin
               s_d.cnt = '0;
            end else if (s_q.cnt == 14'(tag_pkg::LOAD_CYC - 1)) begin
               s_d.cfg = mem_rd_data[31:0];
               s_d.cnt = '0;
               s_d.st = mem_rd_data[tag_pkg::PORDLY_BIT] ? tag_pkg::ST_DAMP : tag_pkg::ST_READ;
               s_d.init_done = ~mem_rd_data[tag_pkg::PORDLY_BIT];
               s_d.fetch = 2'h0;
               s_d.blk = (mem_rd_data[tag_pkg::LAST_READ_BLOCK_LSB +: 3] == 3'h0) ? 4'h0 : 4'h1;
            end
         end
         tag_pkg::ST_DAMP: begin
            s_d.damp = 1'b1;
            s_d.cnt = s_q.cnt + 14'h0001;
            if (gap_edge) begin
               s_d.cnt = '0;
               s_d.st = tag_pkg::ST_LOAD;
            end else if (s_q.cnt == 14'(POR_DELAY_CYCLES - 1)) begin
               s_d.st = tag_pkg::ST_READ;
               s_d.init_done = 1'b1;
            end
         end
         tag_pkg::ST_READ: begin
            unique case (s_q.fetch)
               2'h0: begin
                  s_d.damp = 1'b0;
                  s_d.fetch = 2'h1;
               end
               2'h1: begin
                  s_d.cfg = mem_rd_data[31:0];
                  mem_rd_addr = s_q.blk;
                  s_d.fetch = 2'h2;
               end
               2'h2: begin
                  mem_rd_addr = s_q.blk;
                  s_d.fetch = 2'h3;
               end
               2'h3: begin
                  if (s_q.bitn == 5'h00 && s_q.rc == 8'h00) begin
                     s_d.word = mem_rd_data[31:0];
                  end
                  mem_rd_addr = s_q.blk;
                  s_d.damp = enc ^ s_q.sens_s2;
                  s_d.rc = s_q.rc + 8'h01;
                  if (s_q.rc == div - 8'h01) begin
                     s_d.rc = '0;
                     s_d.bp = ~(s_q.bp ^ bit_val);
                     s_d.bitn = s_q.bitn + 5'h01;
                     if (s_q.bitn == 5'h1F) begin
                        s_d.fetch = 2'h0;
                        s_d.blk = ({1'b0, last_read_block} <= s_q.blk) ? first_blk : s_q.blk + 4'h1;
                     end
                  end
               end
            endcase
            if (s_q.bitn == 5'h00 && s_q.rc == 8'h00 && s_q.fetch == 2'h2) begin
               s_d.word = mem_rd_data[31:0];
            end
            if (gap_edge) begin
               s_d.st = tag_pkg::ST_RX;
               s_d.damp = 1'b0;
               s_d.cnt = '0;
               s_d.nbits = '0;
               s_d.body = '0;
            end
         end
         tag_pkg::ST_RX: begin
            s_d.damp = 1'b0;
            if (s_q.cnt != 14'h3FFF) begin
               s_d.cnt = s_q.cnt + 14'h0001;
            end
            if (gap_edge) begin
               s_d.cnt = '0;
               s_d.nbits = s_q.nbits + 7'h01;
               if (s_q.cnt < 14'(tag_pkg::ZERO_MIN_CYC) || s_q.nbits == 7'h46) begin
                  s_d.frame_error = 1'b1;
                  s_d.st = tag_pkg::ST_READ;
                  s_d.fetch = 2'h0;
               end else if (s_q.nbits < 7'h02) begin
                  s_d.op = {s_q.op[0], s_q.cnt >= 14'(tag_pkg::ONE_MIN_CYC)};
               end else begin
                  s_d.body = {s_q.body[66:0], s_q.cnt >= 14'(tag_pkg::ONE_MIN_CYC)};
               end
            end else if (s_q.cnt == 14'(tag_pkg::FRAME_END_CYC)) begin
               s_d.st = tag_pkg::ST_READ;
               s_d.fetch = 2'h0;
               s_d.bitn = '0;
               s_d.rc = '0;
               s_d.blk = first_blk;
               s_d.tgt = {1'b0, s_q.body[2:0]};
               s_d.is_write = (body_len == tag_pkg::LEN_WRITE) ||
                              (body_len == tag_pkg::LEN_WRITE + tag_pkg::LEN_PWD);
               if (s_q.op == tag_pkg::OP_RESET && s_q.nbits == 7'h02) begin
                  s_d.st = tag_pkg::ST_READ;
               end else if (s_q.op == tag_pkg::OP_TEST && key == tag_pkg::KEY_NO_TEST) begin
                  s_d.st = tag_pkg::ST_READ;
               end else if (s_q.nbits < 7'h02 || !len_ok || s_q.op == tag_pkg::OP_RESET) begin
                  s_d.frame_error = 1'b1;
               end else begin
                  s_d.st = tag_pkg::ST_CHKPW;
                  if (s_q.op == tag_pkg::OP_PAGE1) begin
                     s_d.tgt = tag_pkg::PAGE1_BASE + {1'b0, s_q.body[2:0]};
                  end
               end
            end
         end
         tag_pkg::ST_CHKPW: begin
            mem_rd_addr = tag_pkg::PWD_BLOCK;
            s_d.st = tag_pkg::ST_CHKLOCK;
         end
         tag_pkg::ST_CHKLOCK: begin
            mem_rd_addr = s_q.tgt;
            s_d.st = tag_pkg::ST_WRITE;
            if (s_q.cfg[tag_pkg::PWD_BIT] && rx_pw != mem_rd_data[31:0]) begin
               s_d.st = tag_pkg::ST_READ;
            end
         end
         tag_pkg::ST_WRITE: begin
            s_d.st = tag_pkg::ST_READ;
            if (!s_q.is_write) begin
               s_d.blk = s_q.tgt;
            end else if (!mem_rd_data[tag_pkg::LOCK_BIT] && s_q.op != tag_pkg::OP_PAGE1
                         && s_q.tgt < 4'(tag_pkg::BLOCKS)) begin
               mem_wr_en = 1'b1;
               s_d.write_done = 1'b1;
            end
         end
      endcase

      if (!s_q.por_s2) begin
         s_d.st = tag_pkg::ST_HOLD;
         s_d.damp = 1'b0;
         s_d.init_done = 1'b0;
      end
   end

   // ======================================================
   // state register, clocked by the recovered carrier
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.st <= tag_pkg::ST_HOLD;
         s_q.cfg <= tag_pkg::CFG_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign antenna_damping = s_q.damp;
   assign tag_configuration = s_q.cfg;
   assign init_done = s_q.init_done;
   assign write_done = s_q.write_done;
   assign frame_error = s_q.frame_error;

endmodule : tag_controller

// ### tag_controller_monitor.sv
`timescale 1ns/1ns

module tag_controller_monitor #(
   parameter int POR_DELAY_CYCLES = tag_pkg::POR_DELAY_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic por_ok,
   input wire logic field_gap,
   input wire logic sensor_high_r,
   input wire logic antenna_damping,
   input wire logic [31:0] tag_configuration,
   input wire logic init_done,
   input wire logic write_done,
   input wire logic frame_error
);
   logic gap_prev_q;
   logic [7:0] gap_age_q;
   logic [15:0] quiet_q;
   logic [15:0] damp_q;

   // ======================================================
   // helper counters: age of last gap, quiet start-up time, damping run
   always_ff @(posedge sys_clk) begin
      gap_prev_q <= field_gap;
      if (sys_rst) begin
         gap_age_q <= 8'hFF;
      end else if (field_gap && !gap_prev_q) begin
         gap_age_q <= 8'h00;
      end else if (gap_age_q != 8'hFF) begin
         gap_age_q <= gap_age_q + 8'h01;
      end
      if (sys_rst || !por_ok || (field_gap && !gap_prev_q)) begin
         quiet_q <= 16'h0000;
      end else if (quiet_q != 16'hFFFF) begin
         quiet_q <= quiet_q + 16'h0001;
      end
      if (!antenna_damping) begin
         damp_q <= 16'h0000;
      end else if (damp_q != 16'hFFFF) begin
         damp_q <= damp_q + 16'h0001;
      end
   end

   // ======================================================
   // properties
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   property p_reset_cfg;
      $fell(sys_rst) |-> tag_configuration == tag_pkg::CFG_RESET && !init_done;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg)
      else $error("configuration not at factory value after reset");

   property p_por_hold;
      !por_ok [*5] |-> !init_done && !antenna_damping;
   endproperty
   a_por_hold: assert property (p_por_hold)
      else $error("logic active without supply good");

   property p_init_min;
      $rose(init_done) |-> quiet_q >= tag_pkg::LOAD_FC;
   endproperty
   a_init_min: assert property (p_init_min)
      else $error("start-up shorter than load time since last gap");

   property p_por_delay;
      $rose(init_done) && tag_configuration[tag_pkg::PORDLY_BIT] |->
         damp_q >= 16'(POR_DELAY_CYCLES - 1) && antenna_damping;
   endproperty
   a_por_delay: assert property (p_por_delay)
      else $error("start-up damping shorter than delay");

   property p_wd_time;
      write_done |-> gap_age_q >= 8'h4A && gap_age_q <= 8'h54;
   endproperty
   a_wd_time: assert property (p_wd_time)
      else $error("write commit not at frame end");

   property p_wd_pulse;
      write_done |=> !write_done && !frame_error;
   endproperty
   a_wd_pulse: assert property (p_wd_pulse)
      else $error("write commit pulse too long");

   property p_fe_pulse;
      frame_error |=> !frame_error && !write_done;
   endproperty
   a_fe_pulse: assert property (p_fe_pulse)
      else $error("frame error pulse too long");

   property p_quiet_rx;
      $rose(field_gap) && init_done |-> ##6 !antenna_damping [*8];
   endproperty
   a_quiet_rx: assert property (p_quiet_rx)
      else $error("load modulation during downlink");

endmodule : tag_controller_monitor

bind tag_controller tag_controller_monitor #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES)) u_monitor (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .por_ok(por_ok),
   .field_gap(field_gap),
   .sensor_high_r(sensor_high_r),
   .antenna_damping(antenna_damping),
   .tag_configuration(tag_configuration),
   .init_done(init_done),
   .write_done(write_done),
   .frame_error(frame_error)
);

// ### reader_model.sv
`timescale 1ns/1ns

module reader_model (
   input wire logic sys_clk,
   output logic field_gap
);
   initial field_gap = 1'b0;

   // ======================================================
   // one gap of full carrier loss, then field on until the interval ends
   task automatic gap_then(input int interval);
      @(posedge sys_clk);
      field_gap <= 1'b1;
      repeat (6) @(posedge sys_clk);
      field_gap <= 1'b0;
      repeat (interval - 7) @(posedge sys_clk);
   endtask : gap_then

   // bits msb first, opcode leading; a non-zero spacing forces every bit interval, the closing interval is always 120
   task automatic send(input logic [69:0] bits, input int n, input int spacing);
      int iv;
      for (int i = n - 1; i >= 0; i--) begin
         iv = bits[i] ? 46 + int'($urandom_range(15)) : 20 + int'($urandom_range(11));
         gap_then(spacing != 0 ? spacing : iv);
      end
      gap_then(120);
   endtask : send

endmodule : reader_model

// ### tb_tag_controller.sv
`timescale 1ns/1ns

module tb_tag_controller;
   localparam int POR_DLY = 20;
   logic sys_clk;
   logic sys_rst;
   logic por_ok;
   logic field_gap;
   logic sensor_high_r;
   logic antenna_damping;
   logic [31:0] tag_configuration;
   logic init_done;
   logic write_done;
   logic frame_error;
   int n_fail;
   int comparisons;
   logic armed;
   logic [1:0] ev_exp;
   logic [31:0] cfg_seen;
   logic [31:0] cfg_new;
   logic [31:0] pw;
   logic [1:0] ev_q[$];
   logic [31:0] cfg_q[$];

   tag_controller #(.POR_DELAY_CYCLES(POR_DLY)) DUT (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .por_ok(por_ok),
      .field_gap(field_gap),
      .sensor_high_r(sensor_high_r),
      .antenna_damping(antenna_damping),
      .tag_configuration(tag_configuration),
      .init_done(init_done),
      .write_done(write_done),
      .frame_error(frame_error)
   );

   reader_model rdr (
      .sys_clk(sys_clk),
      .field_gap(field_gap)
   );

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // ======================================================
   // shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic stop_test();
      if (n_fail == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic write_blk(input logic [1:0] op, input logic lock, input logic [31:0] data,
                            input logic [2:0] addr);
      rdr.send({32'h0, op, lock, data, addr}, 38, 0);
   endtask : write_blk

   task automatic wait_init(input int least, input string name);
      int t;
      t = 0;
      while (init_done !== 1'b1 && t < 2000) begin
         @(posedge sys_clk);
         t++;
      end
      check(name, {31'h0, init_done === 1'b1 && t >= least}, 32'h1);
   endtask : wait_init

   task automatic wait_idle(input int limit);
      for (int i = 0; i < limit && ev_q.size() + cfg_q.size() != 0; i++) begin
         @(posedge sys_clk);
      end
   endtask : wait_idle

   // ======================================================
   // result watcher: each pulse or configuration change takes the oldest note
   always @(posedge sys_clk) begin
      if (armed && (write_done === 1'b1 || frame_error === 1'b1)) begin
         ev_exp = ev_q.size() != 0 ? ev_q.pop_front() : 2'h0;
         check("event", {30'h0, frame_error, write_done}, {30'h0, ev_exp});
      end
      if (armed && tag_configuration !== cfg_seen) begin
         check("config", tag_configuration, cfg_q.size() != 0 ? cfg_q.pop_front() : cfg_seen);
         cfg_seen = tag_configuration;
      end
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      n_fail++;
      stop_test();
   end

   // ======================================================
   // main sequence
   initial begin
      void'($urandom(97));
      n_fail = 0;
      comparisons = 0;
      armed = 1'b0;
      sys_rst = 1'b1;
      por_ok = 1'b0;
      sensor_high_r = 1'b0;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      sensor_high_r <= 1'($urandom_range(1));
      @(posedge sys_clk);
      check("reset config", tag_configuration, tag_pkg::CFG_RESET);
      check("reset init", {31'h0, init_done}, 32'h0);
      cfg_seen = tag_configuration;
      armed = 1'b1;
      por_ok <= 1'b1;
      repeat (100) @(posedge sys_clk);
      rdr.gap_then(8);
      // load time runs from the gap start, seven clocks before this point
      wait_init(tag_pkg::LOAD_FC - 8, "restarted start-up");
      ev_q.push_back(2'h1);
      write_blk(tag_pkg::OP_PAGE0, 1'b0, $urandom, 3'h1);
      ev_q.push_back(2'h2);
      rdr.send(70'h0, 1, 10);
      ev_q.push_back(2'h2);
      rdr.send(70'h4, 3, 0);
      ev_q.push_back(2'h1);
      write_blk(tag_pkg::OP_PAGE0, 1'b1, $urandom, 3'h2);
      write_blk(tag_pkg::OP_PAGE0, 1'b0, $urandom, 3'h2);
      pw = $urandom;
      ev_q.push_back(2'h1);
      write_blk(tag_pkg::OP_PAGE0, 1'b0, pw, 3'h7);
      cfg_new = {tag_pkg::KEY_NO_TEST, 28'h0148011};
      ev_q.push_back(2'h1);
      cfg_q.push_back(cfg_new);
      write_blk(tag_pkg::OP_PAGE0, 1'b0, cfg_new, 3'h0);
      wait_idle(4000);
      // password mode now on: a wrong password is ignored, the right one writes
      rdr.send({tag_pkg::OP_PAGE0, ~pw, 1'b0, 32'h0, 3'h3}, 70, 0);
      ev_q.push_back(2'h1);
      rdr.send({tag_pkg::OP_PAGE0, pw, 1'b0, $urandom, 3'h3}, 70, 0);
      write_blk(tag_pkg::OP_TEST, 1'b0, $urandom, 3'h3);
      rdr.send(70'h0, 2, 0);
      por_ok <= 1'b0;
      sensor_high_r <= ~sensor_high_r;
      repeat (8) @(posedge sys_clk);
      check("supply drop", {31'h0, init_done}, 32'h0);
      por_ok <= 1'b1;
      wait_init(tag_pkg::LOAD_FC + POR_DLY, "delayed start-up");
      check("start-up damping", {31'h0, antenna_damping}, 32'h1);
      repeat (200) @(posedge sys_clk);
      check("notes left", ev_q.size() + cfg_q.size(), 32'h0);
      stop_test();
   end

endmodule : tb_tag_controller
